/* File: rtl/dcfi_defs.svh */
// constants for the frame number and identification read commands
// assumes inclusion by bare name from design and bench files
`ifndef DCFI_DEFS_SVH
`define DCFI_DEFS_SVH

`define DCFI_CMD_READ_FRAME  8'hB4
`define DCFI_CMD_READ_IDENT  8'hB5
`define DCFI_IDENTITY_BYTE   8'h5A // arbitrary identity value
`define DCFI_REV_MAJOR       4'h1  // arbitrary revision, tens digit
`define DCFI_REV_MINOR       4'h0  // arbitrary revision, units digit
`define DCFI_CMD_MSB         7
`define DCFI_CMD_LSB         0
`define DCFI_WORD_W          16
`define DCFI_FRAME_HIGH_MSB  10
`define DCFI_FRAME_HIGH_LSB  8
`define DCFI_FRAME_LOW_MSB   7
`define DCFI_FRAME_LOW_LSB   0
`define DCFI_FRAME_RESET     11'h000
`define DCFI_WORD_ZERO       16'h0000

`endif

/* File: rtl/dcfi_pkg.sv */
// types for the frame number and identification read block
// assumes the constants header is compiled alongside
`default_nettype none
package dcfi_pkg;
    typedef enum logic [2:0] {
        DCFI_IDLE  = 3'h1,
        DCFI_FRAME = 3'h2,
        DCFI_IDENT = 3'h4
    } dcfi_state_t;
endpackage : dcfi_pkg
`default_nettype wire

/* File: rtl/dcfi_frame_if.sv */
// interface carrying the latched frame number between the modules
// assumes one clock domain
`default_nettype none
interface dcfi_frame_if;
    logic [10:0] frame_num;
    modport src (output frame_num);
    modport dst (input  frame_num);
endinterface : dcfi_frame_if
`default_nettype wire

/* File: rtl/dcfi_frame_latch.sv */
// holds the last received frame number
// assumes sof_valid_i is a one-cycle pulse from the serial engine
`include "dcfi_defs.svh"
`default_nettype none
module dcfi_frame_latch (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // frame capture
    input  wire logic        sof_valid_i,
    input  wire logic [10:0] sof_frame_i,
    // latched value
    dcfi_frame_if.src        frm
);
    logic [10:0] frame_reg;

    // capture on every start of frame; a reset clears the value to zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frame_reg <= `DCFI_FRAME_RESET;
        end else if (sof_valid_i) begin
            frame_reg <= sof_frame_i;
        end
    end

    assign frm.frame_num = frame_reg;
endmodule : dcfi_frame_latch
`default_nettype wire

/* File: rtl/dcfi_cmd_read.sv */
// command interpreter for frame number and identification reads
// assumes bus strobes are synchronous one-cycle pulses from the bus front end
`include "dcfi_defs.svh"
`default_nettype none
module dcfi_cmd_read (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // processor bus
    input  wire logic        cmd_data_select_i,
    input  wire logic        wr_strobe_i,
    input  wire logic        rd_strobe_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             rdata_valid_o,
    // serial engine
    input  wire logic        sof_valid_i,
    input  wire logic [10:0] sof_frame_i
);
    // latched frame number from the capture module
    dcfi_frame_if frm ();

    // pending command, one-hot
    dcfi_pkg::dcfi_state_t state_reg;
    dcfi_pkg::dcfi_state_t state_next;

    // answer word and its one-cycle valid flag
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        valid_reg;
    logic        valid_next;

    // command code match, shared by the command decodes
    function automatic logic code_is(
        input logic [7:0] code,
        input logic [7:0] want
    );
        return (code == want);
    endfunction : code_is

    // pending command test, shared by the state decodes
    function automatic logic pending_is(
        input dcfi_pkg::dcfi_state_t cur,
        input dcfi_pkg::dcfi_state_t want
    );
        return (cur == want);
    endfunction : pending_is

    // frame capture on every start of frame
    dcfi_frame_latch u_latch (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .sof_valid_i (sof_valid_i),
        .sof_frame_i (sof_frame_i),
        .frm         (frm)
    );

    // bus phase decode; select high marks the command phase
    wire         cmd_wr    = wr_strobe_i & cmd_data_select_i;
    wire         data_rd   = rd_strobe_i & ~cmd_data_select_i;
    wire  [7:0]  cmd_code  = wdata_i[`DCFI_CMD_MSB:`DCFI_CMD_LSB]; // upper byte ignored

    // command decode; any other code drops the pending command
    wire         cmd_frame = cmd_wr & code_is(cmd_code, `DCFI_CMD_READ_FRAME);
    wire         cmd_ident = cmd_wr & code_is(cmd_code, `DCFI_CMD_READ_IDENT);
    wire         cmd_other = cmd_wr & ~cmd_frame & ~cmd_ident;

    // state decode of the pending command
    wire         in_idle   = pending_is(state_reg, dcfi_pkg::DCFI_IDLE);
    wire         in_frame  = pending_is(state_reg, dcfi_pkg::DCFI_FRAME);
    wire         in_ident  = pending_is(state_reg, dcfi_pkg::DCFI_IDENT);

    // guard against a corrupted state word
    wire         state_legal = in_idle | in_frame | in_ident;

    // read decode; a read with nothing pending gets no answer
    wire         rd_frame  = data_rd & in_frame;
    wire         rd_ident  = data_rd & in_ident;
    wire         rd_any    = rd_frame | rd_ident;

    // identification word: fixed identity byte over the decimal revision
    wire  [7:0]  rev_byte  = {`DCFI_REV_MAJOR, `DCFI_REV_MINOR};
    wire  [15:0] id_word   = {`DCFI_IDENTITY_BYTE, rev_byte};

    // frame word: low field, high field, spare bits read as zero
    wire  [15:0] frame_word;
    genvar       lo_i;
    genvar       hi_i;
    genvar       sp_i;

    // low eight frame bits
    generate
        for (lo_i = `DCFI_FRAME_LOW_LSB; lo_i <= `DCFI_FRAME_LOW_MSB; lo_i = lo_i + 1) begin : g_low
            assign frame_word[lo_i] = frm.frame_num[lo_i];
        end
    endgenerate

    // high three frame bits
    generate
        for (hi_i = `DCFI_FRAME_HIGH_LSB; hi_i <= `DCFI_FRAME_HIGH_MSB; hi_i = hi_i + 1) begin : g_high
            assign frame_word[hi_i] = frm.frame_num[hi_i];
        end
    endgenerate

    // spare bits above the frame number
    generate
        for (sp_i = `DCFI_FRAME_HIGH_MSB + 1; sp_i < `DCFI_WORD_W; sp_i = sp_i + 1) begin : g_spare
            assign frame_word[sp_i] = 1'b0;
        end
    endgenerate

    // answer selection, zero when no answer is due
    wire  [15:0] answer_word = rd_frame ? frame_word
                             : rd_ident ? id_word
                             : `DCFI_WORD_ZERO;

    // next pending command; a command write outranks a data read
    always_comb begin
        state_next = state_reg;
        if (cmd_frame) begin
            state_next = dcfi_pkg::DCFI_FRAME;
        end else if (cmd_ident) begin
            state_next = dcfi_pkg::DCFI_IDENT;
        end else if (cmd_other) begin
            state_next = dcfi_pkg::DCFI_IDLE;
        end else if (data_rd) begin
            unique case (state_reg)
                dcfi_pkg::DCFI_FRAME: begin
                    state_next = dcfi_pkg::DCFI_IDLE; // one word only
                end
                dcfi_pkg::DCFI_IDENT: begin
                    state_next = dcfi_pkg::DCFI_IDLE; // one word only
                end
                dcfi_pkg::DCFI_IDLE: begin
                    state_next = dcfi_pkg::DCFI_IDLE;
                end
                default: begin
                    state_next = dcfi_pkg::DCFI_IDLE;
                end
            endcase
        end else if (!state_legal) begin
            state_next = dcfi_pkg::DCFI_IDLE;
        end
    end

    // answer for the cycle after the read
    assign rdata_next = answer_word;
    assign valid_next = rd_any;

    // pending command register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= dcfi_pkg::DCFI_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // answer word register, zero outside the answer cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= `DCFI_WORD_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // answer valid register, one pulse per accepted read
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // outputs straight from the registers
    assign rdata_o       = rdata_reg;
    assign rdata_valid_o = valid_reg;
endmodule : dcfi_cmd_read
`default_nettype wire

/* File: verification/dcfi_cmd_read_assertions.sv */
// checker for the frame number and identification read commands
// assumes binding onto dcfi_cmd_read, one clock domain
`include "dcfi_defs.svh"
`default_nettype none
module dcfi_cmd_read_assertions (
    // bus and answer
    input wire logic clk_i, srst_i, cmd_data_select_i, wr_strobe_i, rd_strobe_i,
    input wire logic [15:0] wdata_i, rdata_o,
    input wire logic rdata_valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // command then data read sequences
    sequence s_cmd(c);
        wr_strobe_i && cmd_data_select_i && wdata_i[7:0] == c;
    endsequence
    sequence s_rd;
        rd_strobe_i && !cmd_data_select_i && !wr_strobe_i;
    endsequence
    property p_frame;
        s_cmd(`DCFI_CMD_READ_FRAME) ##1 s_rd |=> rdata_valid_o && rdata_o[15:11] == 5'h00;
    endproperty
    a_frame: assert property (p_frame) else $error("frame word bad");
    property p_ident;
        s_cmd(`DCFI_CMD_READ_IDENT) ##1 s_rd |=> rdata_valid_o
            && rdata_o == {`DCFI_IDENTITY_BYTE, `DCFI_REV_MAJOR, `DCFI_REV_MINOR};
    endproperty
    a_ident: assert property (p_ident) else $error("ident word bad");
    property p_bcd;
        s_cmd(`DCFI_CMD_READ_IDENT) ##1 s_rd |=> rdata_o[7:4] <= 4'h9 && rdata_o[3:0] <= 4'h9;
    endproperty
    a_bcd: assert property (p_bcd) else $error("revision not decimal");
    property p_once;
        rdata_valid_o |=> !rdata_valid_o;
    endproperty
    a_once: assert property (p_once) else $error("word repeated");
    property p_cause;
        !(rd_strobe_i && !cmd_data_select_i) |=> !rdata_valid_o;
    endproperty
    a_cause: assert property (p_cause) else $error("answer without read");
    property p_quiet;
        !rdata_valid_o |-> rdata_o == 16'h0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data outside answer");
    // main scenarios reached
    c_frame: cover property (s_cmd(`DCFI_CMD_READ_FRAME) ##1 s_rd);
    c_ident: cover property (s_cmd(`DCFI_CMD_READ_IDENT) ##1 s_rd);
    c_stray: cover property (s_rd ##1 s_rd);
endmodule : dcfi_cmd_read_assertions
bind dcfi_cmd_read dcfi_cmd_read_assertions u_chk (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .cmd_data_select_i (cmd_data_select_i),
    .wr_strobe_i       (wr_strobe_i),
    .rd_strobe_i       (rd_strobe_i),
    .wdata_i           (wdata_i),
    .rdata_o           (rdata_o),
    .rdata_valid_o     (rdata_valid_o)
);
`default_nettype wire

/* File: verification/dcfi_host_model.sv */
// processor side of the bus: command writes and data reads
// assumes a registered one-cycle answer after each data read
`default_nettype none
module dcfi_host_model (
    // bus
    input  wire logic        clk_i,
    output logic             sel_o, wr_o, rd_o,
    output logic      [15:0] wdata_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        valid_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {sel_o, wr_o, rd_o, wdata_o} = 19'h00000;
    // command phase, code on low byte; released data flips
    task automatic cmd(input logic [15:0] w);
        {sel_o, wr_o, wdata_o} = {2'b11, w};
        @(negedge clk_i) {sel_o, wr_o, wdata_o} = {2'b00, ~w};
    endtask : cmd
    // data phase, word sampled while the answer stands, then one idle edge
    task automatic rd(output logic [15:0] d, output logic v);
        rd_o = 1'b1;
        @(negedge clk_i) {v, d} = {valid_i, rdata_i};
        rd_o = 1'b0;
        @(negedge clk_i);
    endtask : rd
endmodule : dcfi_host_model
`default_nettype wire

/* File: verification/tb_dcfi_frame_and_ident_read.sv */
// self-checking bench for the frame number and identification reads
// assumes the host model drives the bus at falling edges
`include "dcfi_defs.svh"
`default_nettype none
module tb_dcfi_frame_and_ident_read;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, srst_i = 1'b1, sof_v = 1'b0, sel, wr, rd, v, v1;
    logic [10:0] sof_f = 11'h000;
    logic [15:0] wd, rdat, d;
    logic [31:0] seed = 32'h8400;
    int fail_count = 0, checks_done = 0;
    initial forever #20 clk_i = ~clk_i;
    dcfi_cmd_read dut (.clk_i(clk_i), .srst_i(srst_i), .cmd_data_select_i(sel),
        .wr_strobe_i(wr), .rd_strobe_i(rd), .wdata_i(wd), .rdata_o(rdat),
        .rdata_valid_o(v), .sof_valid_i(sof_v), .sof_frame_i(sof_f));
    dcfi_host_model host (.clk_i(clk_i), .sel_o(sel), .wr_o(wr), .rd_o(rd),
        .wdata_o(wd), .rdata_i(rdat), .valid_i(v));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string n, input logic [16:0] e, input logic [16:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        #100000 fail_count++;
        give_verdict();
    end
    // random frames, then every command and the refused reads
    initial begin
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        host.rd(d, v1);
        check("stray read", 17'h00000, {v1, d});
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            {sof_v, sof_f} = {1'b1, seed[10:0]};
            @(negedge clk_i) sof_v = 1'b0;
            host.cmd({seed[31:24], `DCFI_CMD_READ_FRAME});
            host.rd(d, v1);
            check("frame", {6'h20, seed[10:0]}, {v1, d});
            host.rd(d, v1);
            check("second read", 17'h00000, {v1, d});
            host.cmd({seed[23:16], `DCFI_CMD_READ_IDENT});
            host.rd(d, v1);
            check("ident", {1'b1, `DCFI_IDENTITY_BYTE, 8'h10}, {v1, d});
            check("bcd", 17'h00001, 17'(d[7:4] <= 4'h9 && d[3:0] <= 4'h9));
            host.cmd({seed[15:8], `DCFI_CMD_READ_FRAME});
            @(negedge clk_i);
            host.cmd(16'h00C0);
            host.rd(d, v1);
            check("unknown", 17'h00000, {v1, d});
        end
        host.cmd({8'h00, `DCFI_CMD_READ_FRAME});
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        host.rd(d, v1);
        check("after reset", 17'h00000, {v1, d});
        give_verdict();
    end
endmodule : tb_dcfi_frame_and_ident_read
`default_nettype wire
